// >>> src/i2c_master_seq.sv
// Purpose: i2c master start, restart, transmit, ack and stop sequencing with arbitration
// Assumes: avalon-mm master honours waitrequest; pins are open drain with pull-ups
// Notes: bus inputs pass two flops; outputs all come from the state register
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_defs.svh"
module i2c_master_seq (
  input wire logic clk,
  input wire logic rst,
  input wire i2c_seq_pkg::avalon_req_t av,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire i2c_seq_pkg::pin_in_t pins_in,
  output i2c_seq_pkg::pin_out_t pins_out,
  output logic wake
);

  typedef struct packed {
    i2c_seq_pkg::seq_state_t st;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic tx_pend;
    logic scl_oe;
    logic sda_oe;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic scl_m;
    logic scl_s;
    logic en;
    logic pie;
    logic write_collision_flag;
    logic ack_data_value;
    logic ack_sequence_enable;
    logic stop_sequence_enable;
    logic rsen;
    logic sen;
    logic ackstat;
    logic stop_seen;
    logic start_seen;
    logic bf;
    logic pif;
    logic bcl;
    logic [6:0] reload;
    logic waitreq;
    logic [31:0] rdata;
    logic wake;
    logic load;
  } seq_reg_t;

  seq_reg_t q;
  seq_reg_t d;
  logic bdone;

  // baud period timer
  baud_generator u_baud (
    .clk(clk),
    .rst(rst),
    .load(q.load),
    .halt(q.st == i2c_seq_pkg::IDLE),
    .reload(q.reload),
    .done(bdone)
  );

  // register read mux
  function automatic logic [31:0] read_word(input seq_reg_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `OFS_CTRL_ONE: begin
        w[`C1_WRITE_COLLISION_FLAG] = s.write_collision_flag;
        w[`C1_EN] = s.en;
        w[`C1_PIE] = s.pie;
      end
      `OFS_CTRL_TWO: begin
        w[`C2_ACKSTAT] = s.ackstat;
        w[`C2_ACK_DATA_VALUE] = s.ack_data_value;
        w[`C2_ACK_SEQUENCE_ENABLE] = s.ack_sequence_enable;
        w[`C2_PEN] = s.stop_sequence_enable;
        w[`C2_RSEN] = s.rsen;
        w[`C2_SEN] = s.sen;
      end
      `OFS_STATUS: begin
        w[`ST_STOP] = s.stop_seen;
        w[`ST_START] = s.start_seen;
        w[`ST_BF] = s.bf;
      end
      `OFS_BUFFER: w[7:0] = s.shreg;
      `OFS_RELOAD: w[6:0] = s.reload;
      `OFS_FLAGS: begin
        w[`FL_PIF] = s.pif;
        w[`FL_BCL] = s.bcl;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // next state of the whole block
  always_comb begin
    logic coll;
    logic tmr;
    logic wr;
    logic quiet;
    logic start_ev;
    logic stop_ev;
    coll = 1'b0;
    tmr = bdone & ~q.load;
    wr = av.write & ~q.waitreq;
    quiet = (q.st == i2c_seq_pkg::IDLE) & ~(q.sen | q.rsen | q.stop_sequence_enable | q.ack_sequence_enable) & ~q.tx_pend;
    start_ev = q.sda_p & ~q.sda_s & q.scl_s;
    stop_ev = ~q.sda_p & q.sda_s & q.scl_s;
    d = q;
    d.load = 1'b0;

    // two-flop synchronisers and edge history
    d.sda_m = pins_in.sda;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.scl_m = pins_in.scl;
    d.scl_s = q.scl_m;

    // bus handshake: one wait cycle, then answer
    d.waitreq = ~((av.read | av.write) & q.waitreq);
    if (av.read & q.waitreq) begin
      d.rdata = read_word(q, av.address);
    end

    // software writes, hardware sets below win
    if (wr) begin
      case (av.address)
        `OFS_CTRL_ONE: begin
          d.write_collision_flag = av.writedata[`C1_WRITE_COLLISION_FLAG]; // cleared by software
          d.en = av.writedata[`C1_EN];
          d.pie = av.writedata[`C1_PIE];
        end
        `OFS_CTRL_TWO: begin
          d.ack_data_value = av.writedata[`C2_ACK_DATA_VALUE]; // ack choice
          if (quiet) begin
            d.ack_sequence_enable = av.writedata[`C2_ACK_SEQUENCE_ENABLE];
            d.stop_sequence_enable = av.writedata[`C2_PEN];
            d.rsen = av.writedata[`C2_RSEN];
            d.sen = av.writedata[`C2_SEN];
          end
        end
        `OFS_BUFFER: begin
          if (quiet & q.en) begin
            d.shreg = av.writedata[7:0];
            d.tx_pend = 1'b1;
            d.bf = 1'b1;
            d.bitn = 4'h0; // always from the first bit
          end else begin
            d.write_collision_flag = 1'b1; // busy, buffer kept
          end
        end
        `OFS_RELOAD: d.reload = av.writedata[6:0];
        `OFS_FLAGS: begin
          d.pif = av.writedata[`FL_PIF];
          d.bcl = av.writedata[`FL_BCL];
        end
        default: begin
        end
      endcase
    end

    // bus monitor for start and stop conditions
    if (start_ev) begin
      d.start_seen = 1'b1;
      d.stop_seen = 1'b0;
    end
    if (stop_ev) begin
      d.stop_seen = 1'b1;
      d.start_seen = 1'b0;
      if (q.start_seen) begin
        d.pif = 1'b1; // stop on a busy bus
      end
    end

    // sequencer
    case (q.st)
      i2c_seq_pkg::IDLE: begin
        if (q.en & q.sen) begin
          if (~q.sda_s | ~q.scl_s) begin
            coll = 1'b1; // lines already low
          end else begin
            d.load = 1'b1;
            d.st = i2c_seq_pkg::S_CNT;
          end
        end else if (q.en & q.rsen) begin
          d.scl_oe = 1'b1;
          d.st = i2c_seq_pkg::R_LOW;
        end else if (q.en & q.ack_sequence_enable) begin
          d.scl_oe = 1'b1;
          d.sda_oe = ~q.ack_data_value;
          d.load = 1'b1;
          d.st = i2c_seq_pkg::A_LOW;
        end else if (q.en & q.stop_sequence_enable) begin
          d.scl_oe = 1'b1;
          d.sda_oe = 1'b1;
          d.st = i2c_seq_pkg::P_SDA;
        end else if (q.en & q.tx_pend) begin
          d.scl_oe = 1'b1;
          d.sda_oe = ~q.shreg[7];
          d.load = 1'b1;
          d.st = i2c_seq_pkg::T_LOW;
        end
      end
      i2c_seq_pkg::S_CNT: begin
        if (~q.scl_s & q.sda_s) begin
          coll = 1'b1;
        end else if (~q.sda_s | tmr) begin
          d.sda_oe = 1'b1; // early or at count end
          d.load = 1'b1;
          d.st = i2c_seq_pkg::S_HOLD;
        end
      end
      i2c_seq_pkg::S_HOLD: begin
        if (tmr) begin
          d.scl_oe = 1'b1; // scl state ignored here
          d.sen = 1'b0;
          d.pif = 1'b1;
          d.st = i2c_seq_pkg::IDLE;
        end
      end
      i2c_seq_pkg::R_LOW: begin
        if (~q.scl_s) begin
          d.sda_oe = 1'b0;
          d.load = 1'b1;
          d.st = i2c_seq_pkg::R_SDA;
        end
      end
      i2c_seq_pkg::R_SDA: begin
        if (tmr) begin
          if (q.sda_s) begin
            d.scl_oe = 1'b0;
            d.st = i2c_seq_pkg::R_RISE;
          end else begin
            coll = 1'b1;
          end
        end
      end
      i2c_seq_pkg::R_RISE: begin
        if (q.scl_s) begin
          if (~q.sda_s) begin
            coll = 1'b1;
          end else begin
            d.load = 1'b1;
            d.st = i2c_seq_pkg::R_HIGH;
          end
        end
      end
      i2c_seq_pkg::R_HIGH: begin
        if (~q.scl_s & q.sda_s) begin
          coll = 1'b1;
        end else if (tmr) begin
          d.sda_oe = 1'b1;
          d.load = 1'b1;
          d.st = i2c_seq_pkg::R_HOLD;
        end
      end
      i2c_seq_pkg::R_HOLD: begin
        if (tmr) begin
          d.scl_oe = 1'b1; // unconditional
          d.rsen = 1'b0;
          d.pif = 1'b1;
          d.st = i2c_seq_pkg::IDLE;
        end
      end
      i2c_seq_pkg::T_LOW: begin
        if (tmr) begin
          d.scl_oe = 1'b0;
          d.st = i2c_seq_pkg::T_RISE;
        end
      end
      i2c_seq_pkg::T_RISE: begin
        if (q.scl_s) begin
          d.load = 1'b1;
          d.st = i2c_seq_pkg::T_HIGH;
        end
      end
      i2c_seq_pkg::T_HIGH: begin
        if ((q.bitn != `ACK_BIT) & ~q.sda_oe & ~q.sda_s) begin
          coll = 1'b1; // lost arbitration
        end else if (tmr) begin
          d.scl_oe = 1'b1;
          if (q.bitn == `ACK_BIT) begin
            d.ackstat = q.sda_s;
            d.tx_pend = 1'b0;
            d.pif = 1'b1; // byte done, wake source
            d.st = i2c_seq_pkg::IDLE;
          end else begin
            d.bitn = 4'(q.bitn + 4'h1);
            d.shreg = {q.shreg[6:0], 1'b0};
            if (q.bitn == `LAST_DATA_BIT) begin
              d.bf = 1'b0;
              d.sda_oe = 1'b0; // free sda for the slave ack
            end else begin
              d.sda_oe = ~q.shreg[6];
            end
            d.load = 1'b1;
            d.st = i2c_seq_pkg::T_LOW;
          end
        end
      end
      i2c_seq_pkg::A_LOW: begin
        if (tmr) begin
          d.scl_oe = 1'b0;
          d.st = i2c_seq_pkg::A_RISE;
        end
      end
      i2c_seq_pkg::A_RISE: begin
        if (q.scl_s) begin
          d.load = 1'b1; // clock stretch honoured
          d.st = i2c_seq_pkg::A_HIGH;
        end
      end
      i2c_seq_pkg::A_HIGH: begin
        if (~q.sda_oe & ~q.sda_s) begin
          coll = 1'b1; // not-ack overridden
        end else if (tmr) begin
          d.scl_oe = 1'b1;
          d.ack_sequence_enable = 1'b0;
          d.st = i2c_seq_pkg::IDLE;
        end
      end
      i2c_seq_pkg::P_SDA: begin
        if (~q.sda_s) begin
          d.load = 1'b1;
          d.st = i2c_seq_pkg::P_CNT;
        end
      end
      i2c_seq_pkg::P_CNT: begin
        if (tmr) begin
          d.scl_oe = 1'b0;
          d.st = i2c_seq_pkg::P_RISE;
        end
      end
      i2c_seq_pkg::P_RISE: begin
        if (q.scl_s) begin
          d.load = 1'b1;
          d.st = i2c_seq_pkg::P_HIGH;
        end
      end
      i2c_seq_pkg::P_HIGH: begin
        if (~q.scl_s) begin
          coll = 1'b1; // scl pulled low early
        end else if (tmr) begin
          d.sda_oe = 1'b0;
          d.load = 1'b1;
          d.st = i2c_seq_pkg::P_REL;
        end
      end
      i2c_seq_pkg::P_REL: begin
        if (tmr) begin
          if (~q.sda_s) begin
            coll = 1'b1;
          end else begin
            d.stop_sequence_enable = 1'b0;
            d.pif = 1'b1;
            d.st = i2c_seq_pkg::IDLE;
          end
        end
      end
      default: begin
        d.st = i2c_seq_pkg::IDLE;
      end
    endcase

    // bus collision: abort, free lines and buffer
    if (coll) begin
      d.bcl = 1'b1;
      d.st = i2c_seq_pkg::IDLE;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.sen = 1'b0;
      d.rsen = 1'b0;
      d.stop_sequence_enable = 1'b0;
      d.ack_sequence_enable = 1'b0;
      d.tx_pend = 1'b0;
      d.bf = 1'b0;
    end

    // port disabled: stop everything
    if (~q.en) begin
      d.st = i2c_seq_pkg::IDLE;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.sen = 1'b0;
      d.rsen = 1'b0;
      d.stop_sequence_enable = 1'b0;
      d.ack_sequence_enable = 1'b0;
      d.tx_pend = 1'b0;
      d.bf = 1'b0;
      d.start_seen = 1'b0;
      d.stop_seen = 1'b0;
    end

    // wake request while the interrupt is enabled
    d.wake = d.pif & d.pie;
  end

  // state register, reset clears the port
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= i2c_seq_pkg::IDLE;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.reload <= `RELOAD_RST;
      q.waitreq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign av_readdata = q.rdata;
  assign av_waitrequest = q.waitreq;
  assign pins_out = '{scl_o: 1'b0, scl_oe: q.scl_oe, sda_o: 1'b0, sda_oe: q.sda_oe};
  assign wake = q.wake;

endmodule
`default_nettype wire

// >>> inc/i2c_seq_defs.svh
// Purpose: offsets, field positions, reset values and counts of the i2c master sequencer
// Assumes: byte addresses on a 32-bit avalon-mm slave, one word per register
// Notes: included by the design file, the monitor and the testbench
//
// Overview of operation
// - setting ack enable pulls scl low and puts ack data on sda
// - ack: one period, release scl, wait high, one period, scl low, finish
// - buffer write during ack or stop sequence sets write collision, buffer kept
// - setting stop enable with scl held low drives sda low
// - stop: sda seen low, count, release scl, release sda one period later
// - sda rising with scl high sets stop seen; period later stop ends, flag set
// - port keeps working in sleep and wakes the cpu on completed byte
// - reset or disable stops the port and ends any transfer
// - start seen and stop seen clear on reset and while disabled
// - stop detected while bus busy raises the port interrupt flag
// - released sda read low with scl high is a bus collision, go idle
// - collision in transmit halts it, clears buffer full, frees lines and buffer
// - collision in start, restart, stop or ack aborts it and clears its enable
// - buffer write after collision starts again from the first data bit
// - sda or scl low at start of a start condition is a collision
// - start: count from reload bits; scl low while sda high is a collision
// - sda low during first start count asserts sda early, else at count end
// - restart: release sda, count, release scl, sda low when scl high is collision
// - restart: scl low before sda asserted is collision, else sda low then scl low
// - stop: scl high, count, sample sda; sda low or early scl low is collision
`ifndef I2C_SEQ_DEFS_SVH
`define I2C_SEQ_DEFS_SVH

`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_STATUS 8'h08
`define OFS_BUFFER 8'h0C
`define OFS_RELOAD 8'h10
`define OFS_FLAGS 8'h14

`define C1_WRITE_COLLISION_FLAG 7
`define C1_EN 5
`define C1_PIE 0

`define C2_ACKSTAT 6
`define C2_ACK_DATA_VALUE 5
`define C2_ACK_SEQUENCE_ENABLE 4
`define C2_PEN 2
`define C2_RSEN 1
`define C2_SEN 0

`define ST_STOP 4
`define ST_START 3
`define ST_BF 0

`define FL_PIF 0
`define FL_BCL 1

`define RELOAD_RST 7'h09
`define ACK_BIT 4'h8
`define LAST_DATA_BIT 4'h7

`endif

// >>> inc/i2c_seq_pkg.sv
// Purpose: types shared by the i2c master sequencer files
// Assumes: constants come from i2c_seq_defs.svh
// Notes: pins are open drain, so only enables are meaningful
package i2c_seq_pkg;

  // sequencer states
  typedef enum logic [4:0] {
    IDLE, S_CNT, S_HOLD,
    R_LOW, R_SDA, R_RISE, R_HIGH, R_HOLD,
    T_LOW, T_RISE, T_HIGH,
    A_LOW, A_RISE, A_HIGH,
    P_SDA, P_CNT, P_RISE, P_HIGH, P_REL
  } seq_state_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avalon_req_t;

  // sampled bus levels
  typedef struct packed {
    logic scl;
    logic sda;
  } pin_in_t;

  // open-drain drive of the bus
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } pin_out_t;

endpackage

// >>> src/baud_generator.sv
// Purpose: reloadable down counter giving one baud period per load
// Assumes: load and halt come from logic on the same clock
// Notes: done pulses one cycle when the count reaches zero
`timescale 1ns/1ps
`default_nettype none
module baud_generator (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic halt,
  input wire logic [6:0] reload,
  output logic done
);

  typedef struct packed {
    logic [6:0] cnt;
    logic run;
    logic done;
  } bg_state_t;

  bg_state_t q;
  bg_state_t d;

  // count down from the reload value, stop at zero
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (halt) begin
      d.run = 1'b0;
    end else if (load) begin
      d.cnt = reload;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt == 7'h00) begin
        d.run = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 7'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule
`default_nettype wire

// >>> sim/i2c_seq_monitor.sv
// Purpose: concurrent checks on the i2c master sequencer ports
// Assumes: pins_in carries the raw wire-and level of each bus line
// Notes: bound to every i2c_master_seq instance
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_defs.svh"
module i2c_seq_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire i2c_seq_pkg::avalon_req_t av,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  input wire i2c_seq_pkg::pin_in_t pins_in,
  input wire i2c_seq_pkg::pin_out_t pins_out,
  input wire logic wake
);
  logic c2_wr;
  // control_two write taken this cycle
  assign c2_wr = av.write && !av_waitrequest && av.address == `OFS_CTRL_TWO;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // port quiet right after any reset cycle
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> av_waitrequest && !pins_out.scl_oe && !pins_out.sda_oe && !wake)
    else $error("port not quiet after reset");
  ack_drive_a: assert property (
    c2_wr && av.writedata[`C2_ACK_SEQUENCE_ENABLE] && !av.writedata[`C2_ACK_DATA_VALUE]
    |-> ##[1:6] (pins_out.scl_oe && pins_out.sda_oe))
    else $error("ack not driven on the bus");
  nack_drive_a: assert property (
    c2_wr && av.writedata[`C2_ACK_SEQUENCE_ENABLE] && av.writedata[`C2_ACK_DATA_VALUE]
    |-> ##[1:6] (pins_out.scl_oe && !pins_out.sda_oe))
    else $error("not-ack not driven on the bus");
  stop_drive_a: assert property (
    c2_wr && av.writedata[`C2_PEN] |-> ##[1:6] pins_out.sda_oe)
    else $error("stop did not pull sda low");
  clock_wait_a: assert property (
    !pins_out.scl_oe && !pins_out.sda_oe && !pins_in.scl |=> !pins_out.scl_oe)
    else $error("scl pulled while line still held low");
  sda_move_a: assert property (
    $rose(pins_out.sda_oe) && !pins_out.scl_oe |-> pins_in.scl)
    else $error("sda pulled with scl released but low");
  sda_hold_a: assert property (
    $fell(pins_out.scl_oe) && pins_out.sda_oe |=> pins_out.sda_oe [*2])
    else $error("sda let go too soon after scl release");
  start_abort_a: assert property (
    c2_wr && av.writedata[`C2_SEN] && !pins_in.sda
    |=> (!pins_out.sda_oe && !pins_out.scl_oe) [*8])
    else $error("start driven onto a busy sda line");
endmodule

bind i2c_master_seq i2c_seq_monitor i2c_seq_monitor_inst (
  .clk(clk), .rst(rst), .av(av), .av_readdata(av_readdata),
  .av_waitrequest(av_waitrequest), .pins_in(pins_in), .pins_out(pins_out), .wake(wake)
);
`default_nettype wire

// >>> sim/i2c_far_end.sv
// Purpose: far side of the bus: wire-and levels, slave ack and clock stretch
// Assumes: both lines have pull-ups, so a released line reads high
// Notes: sda_hold stands in for a second master driving a zero
`timescale 1ns/1ps
`default_nettype none
module i2c_far_end (
  input wire logic clk,
  input wire logic rst,
  input wire i2c_seq_pkg::pin_out_t drv,
  input wire logic sda_hold,
  input wire logic [3:0] stretch,
  output i2c_seq_pkg::pin_in_t bus
);
  logic [3:0] nfall_q;
  logic [3:0] st_q;
  logic ack_q;
  logic scl_p_q;
  logic sda_p_q;

  // wire-and of all parties
  assign bus.scl = !(drv.scl_oe || st_q != 4'h0);
  assign bus.sda = !(drv.sda_oe || ack_q || sda_hold);

  // count scl falls from each start, ack the ninth clock, stretch low phases
  always_ff @(posedge clk) begin
    scl_p_q <= bus.scl;
    sda_p_q <= bus.sda;
    ack_q <= !rst && nfall_q == 4'h9;
    if (rst) begin
      nfall_q <= 4'h0;
      st_q <= 4'h0;
    end else if (bus.scl && scl_p_q && sda_p_q && !bus.sda) begin
      nfall_q <= 4'h0;
    end else if (scl_p_q && !bus.scl) begin
      nfall_q <= (nfall_q == 4'hF) ? nfall_q : nfall_q + 4'h1;
      st_q <= stretch;
    end else if (st_q != 4'h0) begin
      st_q <= st_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/i2c_master_ack_stop_arbitration_tb.sv
// Purpose: register-level tests of ack, stop, collision and reset behaviour
// Assumes: reload of 2 gives a bus clock near 520 ns
// Notes: expected values follow the register map of the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_defs.svh"
module i2c_master_ack_stop_arbitration_tb;
  logic clk;
  logic rst;
  i2c_seq_pkg::avalon_req_t av;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  i2c_seq_pkg::pin_in_t pins_in;
  i2c_seq_pkg::pin_out_t pins_out;
  logic wake;
  logic sda_hold;
  logic [3:0] stretch;
  logic [8:0] cap;
  logic scl_p;
  logic [31:0] d;
  int n_fail;
  int comparisons;

  i2c_master_seq i2c_master_seq_inst (.clk(clk), .rst(rst), .av(av),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .pins_in(pins_in), .pins_out(pins_out), .wake(wake));
  i2c_far_end i2c_far_end_inst (.clk(clk), .rst(rst), .drv(pins_out),
    .sda_hold(sda_hold), .stretch(stretch), .bus(pins_in));

  // 25 MHz clock
  initial clk = 1'h0;
  always #20 clk = ~clk;

  // shift in sda at every scl rise
  always @(posedge clk) begin
    scl_p <= pins_in.scl;
    if (!scl_p && pins_in.scl) begin
      cap <= {cap[7:0], pins_in.sda};
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    av <= '{1'h0, 1'h1, a, v};
    do @(posedge clk); while (av_waitrequest !== 1'h0);
    av <= '0;
  endtask

  task bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    av <= '{1'h1, 1'h0, a, 32'h0000_0000};
    do @(posedge clk); while (av_waitrequest !== 1'h0);
    v = av_readdata;
    av <= '0;
  endtask

  task wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] r;
    for (int k = 0; k < 400; k++) begin
      bus_rd(a, r);
      if (r[b] === v) break;
    end
    check(r[b], v);
  endtask

  task do_start();
    bus_wr(`OFS_CTRL_TWO, 32'h0000_0001);
    wait_bit(`OFS_CTRL_TWO, `C2_SEN, 1'h0);
    bus_wr(`OFS_FLAGS, 32'h0000_0000);
  endtask

  task tally_and_finish();
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    av = '0;
    rst = 1'h1;
    sda_hold = 1'h0;
    stretch = 4'h0;
    scl_p = 1'h1;
    cap = 9'h000;
    n_fail = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    bus_rd(`OFS_RELOAD, d); check(d, 32'h0000_0009);
    bus_rd(`OFS_STATUS, d); check(d, 32'h0000_0000);
    bus_rd(8'h18, d); check(d, 32'h0000_0000);
    bus_wr(`OFS_RELOAD, 32'h0000_0002);
    bus_wr(`OFS_CTRL_ONE, 32'h0000_0021);
    do_start();
    bus_wr(`OFS_BUFFER, 32'h0000_00A5);
    bus_rd(`OFS_STATUS, d); check(d[`ST_BF], 1'h1);
    wait_bit(`OFS_FLAGS, `FL_PIF, 1'h1);
    check(cap[8:1], 8'hA5);
    check(wake, 1'h1);
    bus_rd(`OFS_CTRL_TWO, d); check(d[`C2_ACKSTAT], 1'h0);
    bus_wr(`OFS_FLAGS, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      bus_wr(`OFS_CTRL_TWO, (i == 0) ? 32'h0000_0010 : 32'h0000_0030);
      bus_wr(`OFS_BUFFER, 32'h0000_005A);
      bus_rd(`OFS_CTRL_ONE, d); check(d[`C1_WRITE_COLLISION_FLAG], 1'h1);
      bus_rd(`OFS_STATUS, d); check(d[`ST_BF], 1'h0);
      wait_bit(`OFS_CTRL_TWO, `C2_ACK_SEQUENCE_ENABLE, 1'h0);
      bus_wr(`OFS_CTRL_ONE, 32'h0000_0021);
    end
    bus_wr(`OFS_CTRL_TWO, 32'h0000_0004);
    bus_wr(`OFS_BUFFER, 32'h0000_005A);
    bus_rd(`OFS_CTRL_ONE, d); check(d[`C1_WRITE_COLLISION_FLAG], 1'h1);
    wait_bit(`OFS_CTRL_TWO, `C2_PEN, 1'h0);
    bus_rd(`OFS_STATUS, d); check(d[`ST_STOP], 1'h1);
    bus_rd(`OFS_FLAGS, d); check(d[`FL_PIF], 1'h1);
    check(wake, 1'h1);
    bus_wr(`OFS_FLAGS, 32'h0000_0000);
    bus_wr(`OFS_CTRL_ONE, 32'h0000_0021);
    repeat (2) @(posedge clk);
    check(wake, 1'h0);
    bus_wr(`OFS_CTRL_ONE, 32'h0000_0000);
    bus_rd(`OFS_STATUS, d); check(d[4:3], 2'h0);
    bus_wr(`OFS_CTRL_ONE, 32'h0000_0021);
    sda_hold <= 1'h1;
    repeat (4) @(posedge clk);
    bus_wr(`OFS_CTRL_TWO, 32'h0000_0001);
    wait_bit(`OFS_FLAGS, `FL_BCL, 1'h1);
    bus_rd(`OFS_CTRL_TWO, d); check(d[`C2_SEN], 1'h0);
    sda_hold <= 1'h0;
    repeat (4) @(posedge clk);
    bus_wr(`OFS_FLAGS, 32'h0000_0000);
    do_start();
    sda_hold <= 1'h1;
    // low nibble of ones loses arbitration at the fifth bit, not the first
    bus_wr(`OFS_BUFFER, 32'h0000_000F);
    wait_bit(`OFS_FLAGS, `FL_BCL, 1'h1);
    bus_rd(`OFS_STATUS, d); check(d[`ST_BF], 1'h0);
    check({pins_out.scl_oe, pins_out.sda_oe}, 2'h0);
    sda_hold <= 1'h0;
    repeat (4) @(posedge clk);
    bus_wr(`OFS_FLAGS, 32'h0000_0000);
    stretch <= 4'h8;
    do_start();
    bus_wr(`OFS_BUFFER, 32'h0000_0096);
    wait_bit(`OFS_FLAGS, `FL_PIF, 1'h1);
    check(cap[8:1], 8'h96);
    // repeated start on the held bus, then a reset cut into a transfer
    bus_wr(`OFS_FLAGS, 32'h0000_0000);
    bus_wr(`OFS_CTRL_TWO, 32'h0000_0002);
    wait_bit(`OFS_CTRL_TWO, `C2_RSEN, 1'h0);
    bus_rd(`OFS_FLAGS, d);
    check(d[`FL_PIF], 1'h1);
    check({pins_out.scl_oe, pins_out.sda_oe}, 2'h3);
    bus_wr(`OFS_BUFFER, 32'h0000_0055);
    repeat (6) @(posedge clk);
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    check({pins_out.scl_oe, pins_out.sda_oe}, 2'h0);
    bus_rd(`OFS_CTRL_ONE, d);
    check(d, 32'h0000_0000);
    bus_rd(`OFS_STATUS, d);
    check(d, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
